// File: pkg/irq_flag_pkg.sv
package irq_flag_pkg;
  localparam int NUM_IRQ = 32;
  localparam int NUM_SRC = 7;
  localparam int SEL_W = 2;
  // Source indices on the peripheral side.
  localparam int SRC_CAPTURE = 0;
  localparam int SRC_SPI_RX = 1;
  localparam int SRC_SPI_TX = 2;
  localparam int SRC_UART_RX = 3;
  localparam int SRC_UART_TX = 4;
  localparam int SRC_ADC = 5;
  localparam int SRC_PMP = 6;
  // Request numbers seen by the processor.
  localparam int IRQ_CAPTURE = 5;
  localparam int IRQ_SPI_RX = 24;
  localparam int IRQ_SPI_TX = 25;
  localparam int IRQ_UART_RX = 27;
  localparam int IRQ_UART_TX = 28;
  localparam int IRQ_ADC = 30;
  localparam int IRQ_PMP = 31;
  localparam int IRQ_OF [NUM_SRC] = '{IRQ_CAPTURE, IRQ_SPI_RX, IRQ_SPI_TX, IRQ_UART_RX, IRQ_UART_TX, IRQ_ADC,
                                      IRQ_PMP};
  // Register offsets of the controller end.
  localparam logic [7:0] OFS_FLAGS = 8'h00;
  localparam logic [7:0] OFS_CLEAR = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_MASK = 8'h0C;
  localparam logic [7:0] OFS_REFUSED = 8'h10;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'h0;
endpackage

// File: pkg/irq_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface irq_link_if;
  logic [irq_flag_pkg::NUM_IRQ-1:0] irqReq;
  logic [irq_flag_pkg::NUM_IRQ-1:0] clearReq;
  logic [irq_flag_pkg::NUM_IRQ-1:0] clearRefused;
  modport device (
    output irqReq,
    output clearRefused,
    input clearReq
  );
  modport host (
    input irqReq,
    input clearRefused,
    output clearReq
  );
endinterface
`default_nettype wire

// File: hw/persistent_flag_end.sv
`timescale 1ns/1ns
`default_nettype none
module persistent_flag_end #(
  parameter int DEPTH = 8
) (
  input wire logic clock,
  input wire logic reset,
  irq_link_if.device link,
  input wire logic [irq_flag_pkg::NUM_SRC-1:0] srcPush,
  input wire logic [irq_flag_pkg::NUM_SRC-1:0] srcPop,
  input wire logic [irq_flag_pkg::SEL_W-1:0] captureIrqThreshold,
  input wire logic [irq_flag_pkg::SEL_W-1:0] spiRxLevelSelect,
  input wire logic [irq_flag_pkg::SEL_W-1:0] spiTxLevelSelect,
  input wire logic [irq_flag_pkg::SEL_W-1:0] uartRxLevelSelect,
  input wire logic [irq_flag_pkg::SEL_W-1:0] uartTxLevelSelect,
  input wire logic uartEnable,
  output logic [irq_flag_pkg::NUM_SRC-1:0] sourceCondition
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] CNT_ZERO = '0;
  localparam logic [CW-1:0] CNT_ONE = CW'(1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

  logic [CW-1:0] occupancy_r [irq_flag_pkg::NUM_SRC];
  logic [CW-1:0] txFreeSpi;
  logic [CW-1:0] txFreeUart;
  logic [irq_flag_pkg::NUM_SRC-1:0] cond;
  logic [irq_flag_pkg::NUM_IRQ-1:0] condAt;
  logic [irq_flag_pkg::NUM_IRQ-1:0] flag_r;
  logic [irq_flag_pkg::NUM_IRQ-1:0] refused_r;
  logic [irq_flag_pkg::NUM_SRC-1:0] sourceCondition_r;

  // Each source keeps how many items are stored or owed. A push and a pop in
  // the same cycle cancel, and the count saturates rather than wrapping, so a
  // misbehaving peripheral cannot make the condition vanish by overflow.
  genvar s;
  generate
    for (s = 0; s < irq_flag_pkg::NUM_SRC; s++) begin : g_occ
      always_ff @(posedge clock) begin
        if (reset) begin
          occupancy_r[s] <= CNT_ZERO;
        end else if (s == irq_flag_pkg::SRC_UART_TX && !uartEnable) begin
          occupancy_r[s] <= CNT_ZERO;
        end else if (srcPush[s] && !srcPop[s] && occupancy_r[s] != CNT_FULL) begin
          occupancy_r[s] <= occupancy_r[s] + CNT_ONE;
        end else if (srcPop[s] && !srcPush[s] && occupancy_r[s] != CNT_ZERO) begin
          occupancy_r[s] <= occupancy_r[s] - CNT_ONE;
        end
      end
    end
  endgenerate

  // Transmit sides count free room, so writes into the data buffer are what
  // bring the level below the selected mark.
  assign txFreeSpi = CNT_FULL - occupancy_r[irq_flag_pkg::SRC_SPI_TX];
  assign txFreeUart = CNT_FULL - occupancy_r[irq_flag_pkg::SRC_UART_TX];

  always_comb begin
    cond = '0;
    cond[irq_flag_pkg::SRC_CAPTURE] = occupancy_r[irq_flag_pkg::SRC_CAPTURE] > CW'(captureIrqThreshold);
    cond[irq_flag_pkg::SRC_SPI_RX] = occupancy_r[irq_flag_pkg::SRC_SPI_RX] > CW'(spiRxLevelSelect);
    cond[irq_flag_pkg::SRC_SPI_TX] = txFreeSpi > CW'(spiTxLevelSelect);
    cond[irq_flag_pkg::SRC_UART_RX] = occupancy_r[irq_flag_pkg::SRC_UART_RX] > CW'(uartRxLevelSelect);
    cond[irq_flag_pkg::SRC_UART_TX] = uartEnable && txFreeUart > CW'(uartTxLevelSelect);
    cond[irq_flag_pkg::SRC_ADC] = occupancy_r[irq_flag_pkg::SRC_ADC] != CNT_ZERO;
    cond[irq_flag_pkg::SRC_PMP] = occupancy_r[irq_flag_pkg::SRC_PMP] != CNT_ZERO;
  end

  // Sources are placed on their request numbers; unused numbers stay low.
  always_comb begin
    condAt = '0;
    for (int k = 0; k < irq_flag_pkg::NUM_SRC; k++) begin
      condAt[irq_flag_pkg::IRQ_OF[k]] = cond[k];
    end
  end

  // A live condition wins over a clear in the same cycle, which is exactly
  // the persistent behaviour: software can only drop the flag once the
  // condition is gone, and a returning condition sets it on the next edge.
  genvar i;
  generate
    for (i = 0; i < irq_flag_pkg::NUM_IRQ; i++) begin : g_flag
      always_ff @(posedge clock) begin
        if (reset) begin
          flag_r[i] <= 1'b0;
        end else if (condAt[i]) begin
          flag_r[i] <= 1'b1;
        end else if (link.clearReq[i]) begin
          flag_r[i] <= 1'b0;
        end
      end

      always_ff @(posedge clock) begin
        if (reset) begin
          refused_r[i] <= 1'b0;
        end else begin
          refused_r[i] <= link.clearReq[i] && condAt[i];
        end
      end
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (reset) begin
      sourceCondition_r <= '0;
    end else begin
      sourceCondition_r <= cond;
    end
  end

  assign link.irqReq = flag_r;
  assign link.clearRefused = refused_r;
  assign sourceCondition = sourceCondition_r;
endmodule // persistent_flag_end
`default_nettype wire

// File: hw/irq_flag_host_end.sv
// Added by the designer: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module irq_flag_host_end (
  input wire logic clock,
  input wire logic reset,
  irq_link_if.host link,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq
);
  logic rdAccept;
  logic wrAccept;
  logic wrPending_r;
  logic [7:0] wrAddr_r;
  logic [31:0] hrdata_r;
  logic [31:0] clearReq_r;
  logic [31:0] status_r;
  logic [31:0] mask_r;
  logic [31:0] refusedSeen_r;
  logic [31:0] flagPrev_r;
  logic [31:0] flagRise;
  logic statusRead;
  logic refusedRead;

  // Every transfer completes with no wait state, so read data is fetched in
  // the address phase and a write lands at the end of its data phase.
  assign rdAccept = hsel && hready && htrans == irq_flag_pkg::HTRANS_NONSEQ && !hwrite;
  assign wrAccept = hsel && hready && htrans == irq_flag_pkg::HTRANS_NONSEQ && hwrite;
  assign statusRead = rdAccept && haddr[7:0] == irq_flag_pkg::OFS_STATUS;
  assign refusedRead = rdAccept && haddr[7:0] == irq_flag_pkg::OFS_REFUSED;
  assign flagRise = link.irqReq & ~flagPrev_r;

  always_ff @(posedge clock) begin
    if (reset) begin
      wrPending_r <= 1'b0;
      wrAddr_r <= 8'h00;
    end else begin
      wrPending_r <= wrAccept;
      wrAddr_r <= haddr[7:0];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      hrdata_r <= irq_flag_pkg::RESET_WORD;
    end else if (rdAccept) begin
      unique case (haddr[7:0])
        irq_flag_pkg::OFS_FLAGS: hrdata_r <= link.irqReq;
        irq_flag_pkg::OFS_STATUS: hrdata_r <= status_r;
        irq_flag_pkg::OFS_MASK: hrdata_r <= mask_r;
        irq_flag_pkg::OFS_REFUSED: hrdata_r <= refusedSeen_r;
        default: hrdata_r <= irq_flag_pkg::RESET_WORD;
      endcase
    end
  end

  // Clear requests are one-cycle pulses; the far end decides whether they
  // take effect, so this side never assumes a flag went low.
  always_ff @(posedge clock) begin
    if (reset) begin
      clearReq_r <= irq_flag_pkg::RESET_WORD;
    end else if (wrPending_r && wrAddr_r == irq_flag_pkg::OFS_CLEAR) begin
      clearReq_r <= hwdata;
    end else begin
      clearReq_r <= irq_flag_pkg::RESET_WORD;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      mask_r <= irq_flag_pkg::RESET_WORD;
    end else if (wrPending_r && wrAddr_r == irq_flag_pkg::OFS_MASK) begin
      mask_r <= hwdata;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      flagPrev_r <= irq_flag_pkg::RESET_WORD;
    end else begin
      flagPrev_r <= link.irqReq;
    end
  end

  // A new event in the cycle of the clearing read survives it.
  always_ff @(posedge clock) begin
    if (reset) begin
      status_r <= irq_flag_pkg::RESET_WORD;
    end else if (statusRead) begin
      status_r <= flagRise;
    end else begin
      status_r <= status_r | flagRise;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      refusedSeen_r <= irq_flag_pkg::RESET_WORD;
    end else if (refusedRead) begin
      refusedSeen_r <= link.clearRefused;
    end else begin
      refusedSeen_r <= refusedSeen_r | link.clearRefused;
    end
  end

  assign link.clearReq = clearReq_r;
  assign hrdata = hrdata_r;
  assign hreadyout = 1'b1;
  assign hresp = irq_flag_pkg::HRESP_OKAY;
  assign irq = |(status_r & mask_r);
endmodule // irq_flag_host_end
`default_nettype wire

// File: bench/irq_flag_properties.sv
`timescale 1ns/1ns
`default_nettype none
module irq_flag_properties (
  input wire logic clock,
  input wire logic reset,
  input wire logic [31:0] irqReq,
  input wire logic [31:0] clearReq,
  input wire logic [31:0] clearRefused
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  // Only the seven mapped request numbers may ever be raised.
  localparam logic [31:0] USED = 32'hDB00_0020;
  sequence sRefused(int b);
    clearReq[b] ##1 clearRefused[b] && !clearReq[b];
  endsequence
  property pHeld(int b);
    sRefused(b) |=> irqReq[b];
  endproperty
  a_refuse_holds_flag: assert property ((clearRefused & ~irqReq) == 32'h0000_0000)
    else $error("flag lost");
  a_refuse_has_cause: assert property ((clearRefused & ~$past(clearReq)) == 32'h0000_0000)
    else $error("stray");
  a_unused_bits_zero: assert property ((irqReq & ~USED) == 32'h0000_0000)
    else $error("bad number");
  a_clear_takes_effect: assert property (($past(clearReq) & irqReq & ~clearRefused) == 32'h0000_0000)
    else $error("clear ignored");
  a_flag_sticky: assert property (($past(irqReq) & ~irqReq & ~$past(clearReq)) == 32'h0000_0000)
    else $error("flag fell");
  a_refused_one_cycle: assert property (clearRefused[27] && !clearReq[27] |=> !clearRefused[27])
    else $error("long refusal");
  a_uart_rx_held: assert property (pHeld(27)) else $error("rx flag lost");
  a_spi_rx_held: assert property (pHeld(24)) else $error("spi flag lost");
endmodule // irq_flag_properties
`default_nettype wire

// File: bench/tb_persistent_irq_source_flags.sv
`timescale 1ns/1ns
`default_nettype none
module tb_persistent_irq_source_flags;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic hreadyout;
  logic hresp;
  logic irq;
  logic uartEnable = 1'b0;
  logic [6:0] srcPush = 7'h00;
  logic [6:0] srcPop = 7'h00;
  logic [6:0] cond;
  logic [1:0] sel = 2'h0;
  int failCount = 0;
  int nChecks = 0;
  irq_link_if link();
  persistent_flag_end i_persistent_flag_end (.clock(clock), .reset(reset), .link(link), .srcPush(srcPush),
    .srcPop(srcPop), .captureIrqThreshold(sel), .spiRxLevelSelect(sel), .spiTxLevelSelect(sel),
    .uartRxLevelSelect(sel), .uartTxLevelSelect(sel), .uartEnable(uartEnable), .sourceCondition(cond));
  irq_flag_host_end i_irq_flag_host_end (.clock(clock), .reset(reset), .link(link), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq(irq));
  irq_flag_properties i_irq_flag_properties (.clock(clock), .reset(reset), .irqReq(link.irqReq),
    .clearReq(link.clearReq), .clearRefused(link.clearRefused));
  always #5 clock = ~clock;
  task automatic stopTest;
    $display("checks %0d mismatches %0d", nChecks, failCount);
    if (failCount == 0 && nChecks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      failCount++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic waitReady;
    int k;
    k = 0;
    @(posedge clock);
    while (hreadyout !== 1'b1) begin
      k++;
      if (k > 50) begin
        failCount++;
        $display("BAD %0t timeout", $time);
        stopTest();
      end
      @(posedge clock);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] ofs, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= 32'(ofs);
    htrans <= irq_flag_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    waitReady();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    waitReady();
    rd = hrdata;
    repeat (3) @(posedge clock);
  endtask
  // Strobes are spaced by an idle cycle so each of the n strobes in a step is a separate one-cycle pulse.
  task automatic step(input int s, input logic push, input int n, input logic exp);
    logic [6:0] one;
    one = 7'h01 << s;
    repeat (n) begin
      srcPush <= push ? one : 7'h00;
      srcPop <= push ? 7'h00 : one;
      @(posedge clock);
      srcPush <= 7'h00;
      srcPop <= 7'h00;
      @(posedge clock);
    end
    repeat (3) @(posedge clock);
    chk(cond[s], exp);
  endtask
  task automatic t_uart_tx;
    uartEnable <= 1'b1;
    repeat (2) @(posedge clock);
    chk(link.irqReq[28], 1'b1);
    chk(hresp, irq_flag_pkg::HRESP_OKAY);
    xfer(1'b1, irq_flag_pkg::OFS_MASK, 32'h1000_0000);
    chk(irq, 1'b1);
    xfer(1'b0, irq_flag_pkg::OFS_STATUS, 32'h0000_0000);
    chk(rd & 32'h1000_0000, 32'h1000_0000);
    xfer(1'b0, irq_flag_pkg::OFS_STATUS, 32'h0000_0000);
    chk({rd[31:1], irq}, 32'h0000_0000);
    xfer(1'b1, irq_flag_pkg::OFS_CLEAR, 32'h1000_0000);
    chk(link.irqReq[28], 1'b1);
    xfer(1'b0, irq_flag_pkg::OFS_REFUSED, 32'h0000_0000);
    chk(rd, 32'h1000_0000);
    uartEnable <= 1'b0;
    xfer(1'b1, irq_flag_pkg::OFS_CLEAR, 32'h1000_0000);
    chk(link.irqReq[28], 1'b0);
    xfer(1'b0, irq_flag_pkg::OFS_MASK, 32'h0000_0000);
    chk(rd, 32'h1000_0000);
    xfer(1'b0, 8'h40, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    uartEnable <= 1'b1;
    repeat (2) @(posedge clock);
    chk(link.irqReq[28], 1'b1);
    $display("uart tx done");
  endtask
  task automatic t_uart_rx;
    step(1, 1'b1, 1, 1'b1);
    step(3, 1'b1, 1, 1'b1);
    xfer(1'b1, irq_flag_pkg::OFS_CLEAR, 32'h0900_0000);
    chk({link.irqReq[27], link.irqReq[24]}, 2'h3);
    step(1, 1'b0, 1, 1'b0);
    step(3, 1'b0, 1, 1'b0);
    xfer(1'b1, irq_flag_pkg::OFS_CLEAR, 32'h0900_0000);
    chk({link.irqReq[27], link.irqReq[24]}, 2'h0);
    step(3, 1'b1, 1, 1'b1);
    chk(link.irqReq[27], 1'b1);
    step(3, 1'b0, 1, 1'b0);
    $display("uart rx done");
  endtask
  task automatic t_levels;
    sel <= 2'h2;
    for (int s = 0; s < 7; s++) begin
      if (s == 2 || s == 4) begin
        step(s, 1'b1, 5, 1'b1);
        step(s, 1'b1, 1, 1'b0);
        step(s, 1'b0, 6, 1'b1);
      end else if (s >= 5) begin
        step(s, 1'b1, 2, 1'b1);
        step(s, 1'b0, 1, 1'b1);
        step(s, 1'b0, 1, 1'b0);
      end else begin
        step(s, 1'b1, 2, 1'b0);
        step(s, 1'b1, 1, 1'b1);
        step(s, 1'b0, 3, 1'b0);
      end
    end
    chk(link.irqReq[25:24], 2'h3);
    // Receive is drained but transmit still has room, so only number 25 may survive the clear.
    xfer(1'b1, irq_flag_pkg::OFS_CLEAR, 32'h0300_0000);
    chk(link.irqReq[25:24], 2'h2);
    $display("levels done");
  endtask
  initial begin
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    t_uart_tx();
    t_uart_rx();
    t_levels();
    stopTest();
  end
endmodule // tb_persistent_irq_source_flags
`default_nettype wire
